// *** include/flash_row_params.svh ***
// Offsets, field positions, reset values and timing counts of the row flash controller
`ifndef FLASH_ROW_PARAMS_SVH
`define FLASH_ROW_PARAMS_SVH

// Register addresses
`define ADDR_OP_CONTROL   16'h0760
`define ADDR_TARGET_LOW   16'h0762
`define ADDR_TARGET_HIGH  16'h0764
`define ADDR_UNLOCK_KEY   16'h0766

// flash_op_control fields
`define CTRL_START_BIT    15
`define CTRL_ALLOW_BIT    14
`define CTRL_ABORT_BIT    13
`define CTRL_ERASE_BIT    6
`define CTRL_OP_LSB       0
`define CTRL_OP_W         4
`define CTRL_RESET        16'h0000
`define OP_MULTI_WORD_PM  4'h1

// Unlock key values
`define KEY_FIRST         16'h0055
`define KEY_SECOND        16'h00AA

// Row and panel geometry
`define ROW_WORDS         32
`define ROW_IDX_W         5
`define PANEL_ROWS        128
`define PANEL_LSB         13
`define ROW_LSB           6
`define INSTR_W           24
`define PANEL_COUNT       2

// Timing and FIFO depth
`define CLK_PERIOD_NS     40
`define OP_TIME_NS        2000000
`define FIFO_DEPTH        16

`endif

// *** include/flash_row_pkg.sv ***
// Types shared by the row flash controller
`default_nettype none
package flash_row_pkg;
  typedef enum {OP_IDLE, OP_ERASE, OP_STREAM, OP_WAIT} op_state_t;
  typedef enum {KEY_NONE, KEY_HALF, KEY_ARMED} key_state_t;
endpackage
`default_nettype wire

// *** core/row_latch_mem.sv ***
// Write latch memory, low and high parts written separately, registered read
`default_nettype none
`include "flash_row_params.svh"
module row_latch_mem #(
  parameter int WIDTH = `INSTR_W,
  parameter int DEPTH = `ROW_WORDS * `PANEL_COUNT,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock
  input  wire logic             clk,
  // Write side
  input  wire logic             we_low,
  input  wire logic             we_high,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read side
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we_low)
    begin
      store[waddr][15:0] <= wdata[15:0];
    end
    if (we_high)
    begin
      store[waddr][WIDTH-1:16] <= wdata[WIDTH-1:16];
    end
    rdata <= store[raddr];
  end
endmodule
`default_nettype wire

// *** core/word_fifo.sv ***
// Word FIFO with registered output stage, valid and ready on both sides
`default_nettype none
`include "flash_row_params.svh"
module word_fifo #(
  parameter int WIDTH = `INSTR_W,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr;
  logic [AW-1:0]    rd_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             next_out_valid;
  logic             push, pop;

  always_comb
  begin
    in_ready       = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    push           = in_valid && in_ready;
    pop            = (count != '0) && (!out_valid || out_ready);
    next_wr_ptr    = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr    = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count     = (AW+1)'(count + (AW+1)'(push) - (AW+1)'(pop));
    next_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
    // Abort drops whatever is buffered
    if (clear)
    begin
      next_wr_ptr    = '0;
      next_rd_ptr    = '0;
      next_count     = '0;
      next_out_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      out_valid <= next_out_valid;
      if (pop)
      begin
        out_data <= store[rd_ptr];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// *** core/self_program_flash_row_ctrl.sv ***
// Run-time row erase and program controller for on-chip program flash
`default_nettype none
`include "flash_row_params.svh"
module self_program_flash_row_ctrl
  import flash_row_pkg::*;
#(
  parameter int OP_CYCLES   = `OP_TIME_NS / `CLK_PERIOD_NS,
  parameter int PANEL_COUNT = `PANEL_COUNT,
  parameter int FIFO_DEPTH  = `FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // Register access from the core
  input  wire logic        SFR_WE,
  input  wire logic        SFR_RE,
  input  wire logic [15:0] SFR_ADDR,
  input  wire logic [15:0] SFR_WDATA,
  output logic      [15:0] SFR_RDATA,
  // Table instructions from the core
  input  wire logic        TBL_WE,
  input  wire logic        TBL_RE,
  input  wire logic        TBL_HIGH,
  input  wire logic [15:0] TBL_EA,
  input  wire logic [7:0]  TABLE_PAGE_REG,
  input  wire logic [15:0] TBL_WDATA,
  output logic             TBL_DONE,
  // Core stall and status
  output logic             CPU_STALL,
  output logic             FLASH_DONE_FLAG,
  input  wire logic        FLASH_DONE_CLR,
  input  wire logic        RESET_ABORT_REQ,
  // Flash array
  output logic             FL_ERASE,
  output logic             FL_PROG,
  output logic      [17:0] FL_ROW,
  output logic             FL_VALID,
  input  wire logic        FL_READY,
  output logic      [23:0] FL_DATA
);
  localparam int PSW = (PANEL_COUNT > 1) ? $clog2(PANEL_COUNT) : 1;
  localparam int LAW = `ROW_IDX_W + PSW;
  localparam int TW  = $clog2(OP_CYCLES + 1);

  // ==========================================================
  // State
  // ==========================================================
  op_state_t          state, next_state;
  key_state_t         key, next_key;
  logic               start_bit, next_start_bit;
  logic               allow_bit, next_allow_bit;
  logic               abort_flag, next_abort_flag;
  logic               erase_sel, next_erase_sel;
  logic [3:0]         op_sel, next_op_sel;
  logic [15:0]        target_address_low, next_target_address_low;
  logic [7:0]         target_address_high, next_target_address_high;
  logic [TW-1:0]      timer, next_timer;
  logic [`ROW_IDX_W:0] rd_idx, next_rd_idx;
  logic               rd_pend, next_rd_pend;
  logic [15:0]        next_rdata;
  logic               next_tbl_done, next_stall, next_done_flag;
  logic               next_fl_erase, next_fl_prog;
  logic [17:0]        next_fl_row;

  // Memory and FIFO wires
  logic [23:0]        tbl_addr;
  logic [23:0]        tgt_addr;
  logic [LAW-1:0]     lat_waddr, lat_raddr;
  logic [23:0]        lat_wdata, lat_rdata;
  logic               lat_we_low, lat_we_high;
  logic               fifo_in_ready;
  logic               ctrl_wr, key_wr, low_wr, high_wr;
  logic               go;
  logic               op_abort;

  // ==========================================================
  // Address decode helper
  // ==========================================================
  function automatic logic [LAW-1:0] latch_index(input logic [23:0] a);
    latch_index = {a[`PANEL_LSB +: PSW], a[1 +: `ROW_IDX_W]};
  endfunction

  assign tbl_addr    = {TABLE_PAGE_REG, TBL_EA};
  assign tgt_addr    = {target_address_high, target_address_low};
  assign lat_waddr   = latch_index(tbl_addr);
  assign lat_wdata   = {TBL_WDATA[7:0], TBL_WDATA};
  assign lat_we_low  = TBL_WE && !TBL_HIGH && !start_bit;
  assign lat_we_high = TBL_WE && TBL_HIGH && !start_bit;
  assign lat_raddr   = {tgt_addr[`PANEL_LSB +: PSW], rd_idx[`ROW_IDX_W-1:0]};
  assign op_abort    = RESET_ABORT_REQ && (state != OP_IDLE);

  // ==========================================================
  // Latches and output FIFO
  // ==========================================================
  row_latch_mem #(
    .WIDTH (`INSTR_W),
    .DEPTH (`ROW_WORDS * PANEL_COUNT),
    .AW    (LAW)
  ) row_latch_mem_inst (
    .clk     (CORE_CLK),
    .we_low  (lat_we_low),
    .we_high (lat_we_high),
    .waddr   (lat_waddr),
    .wdata   (lat_wdata),
    .raddr   (lat_raddr),
    .rdata   (lat_rdata)
  );

  word_fifo #(
    .WIDTH (`INSTR_W),
    .DEPTH (FIFO_DEPTH)
  ) word_fifo_inst (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .clear     (op_abort),
    .in_valid  (rd_pend),
    .in_ready  (fifo_in_ready),
    .in_data   (lat_rdata),
    .out_valid (FL_VALID),
    .out_ready (FL_READY),
    .out_data  (FL_DATA)
  );

  // ==========================================================
  // Next values
  // ==========================================================
  always_comb
  begin
    ctrl_wr  = SFR_WE && (SFR_ADDR == `ADDR_OP_CONTROL);
    low_wr   = SFR_WE && (SFR_ADDR == `ADDR_TARGET_LOW);
    high_wr  = SFR_WE && (SFR_ADDR == `ADDR_TARGET_HIGH);
    key_wr   = SFR_WE && (SFR_ADDR == `ADDR_UNLOCK_KEY);
    // Start only when armed, allowed and a row operation is chosen
    go = ctrl_wr && !start_bit && SFR_WDATA[`CTRL_START_BIT]
         && (key == KEY_ARMED)
         && SFR_WDATA[`CTRL_ALLOW_BIT]
         && (SFR_WDATA[`CTRL_OP_LSB +: `CTRL_OP_W] == `OP_MULTI_WORD_PM);

    next_state               = state;
    next_key                 = key;
    next_start_bit           = start_bit;
    next_allow_bit           = allow_bit;
    next_abort_flag          = abort_flag;
    next_erase_sel           = erase_sel;
    next_op_sel              = op_sel;
    next_target_address_low  = target_address_low;
    next_target_address_high = target_address_high;
    next_timer               = timer;
    next_rd_idx              = rd_idx;
    next_rd_pend             = 1'b0;
    next_fl_erase            = 1'b0;
    next_fl_prog             = 1'b0;
    next_fl_row              = FL_ROW;
    next_tbl_done            = TBL_WE;
    next_rdata               = 16'h0000;
    next_done_flag           = FLASH_DONE_FLAG;
    // Clear first so a completion in the same cycle wins
    if (FLASH_DONE_CLR)
    begin
      next_done_flag = 1'b0;
    end

    // Unlock sequence
    if (key_wr)
    begin
      if (SFR_WDATA == `KEY_FIRST)
      begin
        next_key = KEY_HALF;
      end
      else if (SFR_WDATA == `KEY_SECOND && key == KEY_HALF)
      begin
        next_key = KEY_ARMED;
      end
      else
      begin
        next_key = KEY_NONE;
      end
    end
    else if (SFR_WE)
    begin
      next_key = KEY_NONE;
    end

    // Control register, locked while an operation runs
    if (ctrl_wr && !start_bit)
    begin
      next_allow_bit = SFR_WDATA[`CTRL_ALLOW_BIT];
      next_erase_sel = SFR_WDATA[`CTRL_ERASE_BIT];
      next_op_sel    = SFR_WDATA[`CTRL_OP_LSB +: `CTRL_OP_W];
      next_abort_flag = abort_flag & SFR_WDATA[`CTRL_ABORT_BIT];
    end

    // Target address, table capture or direct write
    if (TBL_WE || TBL_RE)
    begin
      next_target_address_low  = TBL_EA;
      next_target_address_high = TABLE_PAGE_REG;
    end
    else if (!start_bit)
    begin
      if (low_wr)
      begin
        next_target_address_low = SFR_WDATA;
      end
      if (high_wr)
      begin
        next_target_address_high = SFR_WDATA[7:0];
      end
    end

    // Register reads, key reads as zero
    if (SFR_RE)
    begin
      case (SFR_ADDR)
        `ADDR_OP_CONTROL:
        begin
          next_rdata[`CTRL_START_BIT]             = start_bit;
          next_rdata[`CTRL_ALLOW_BIT]             = allow_bit;
          next_rdata[`CTRL_ABORT_BIT]             = abort_flag;
          next_rdata[`CTRL_ERASE_BIT]             = erase_sel;
          next_rdata[`CTRL_OP_LSB +: `CTRL_OP_W]  = op_sel;
        end
        `ADDR_TARGET_LOW:  next_rdata = target_address_low;
        `ADDR_TARGET_HIGH: next_rdata = {8'h00, target_address_high};
        default:           next_rdata = 16'h0000;
      endcase
    end

    // Operation sequencer
    case (state)
      OP_IDLE:
      begin
        if (go)
        begin
          next_start_bit = 1'b1;
          next_timer     = TW'(OP_CYCLES);
          next_fl_row    = tgt_addr[23:`ROW_LSB];
          next_rd_idx    = '0;
          if (SFR_WDATA[`CTRL_ERASE_BIT])
          begin
            next_fl_erase = 1'b1;
            next_state    = OP_ERASE;
          end
          else
          begin
            next_fl_prog = 1'b1;
            next_state   = OP_STREAM;
          end
        end
      end
      OP_ERASE:
      begin
        next_state = OP_WAIT;
      end
      OP_STREAM:
      begin
        // Read one latch per free FIFO slot, exactly one row
        if (!rd_pend && fifo_in_ready && rd_idx != (`ROW_IDX_W+1)'(`ROW_WORDS))
        begin
          next_rd_pend = 1'b1;
          next_rd_idx  = (`ROW_IDX_W+1)'(rd_idx + 1'b1);
        end
        else if (!rd_pend && rd_idx == (`ROW_IDX_W+1)'(`ROW_WORDS))
        begin
          next_state = OP_WAIT;
        end
      end
      OP_WAIT:
      begin
        if (timer == '0 && !FL_VALID)
        begin
          next_start_bit = 1'b0;
          next_done_flag = 1'b1;
          next_state     = OP_IDLE;
        end
      end
      default:
      begin
        next_state = OP_IDLE;
      end
    endcase

    if (state != OP_IDLE && timer != '0)
    begin
      next_timer = TW'(timer - 1'b1);
    end

    // Reset request during an operation ends it, address kept
    if (op_abort)
    begin
      next_abort_flag = 1'b1;
      next_rd_pend    = 1'b0;
      next_start_bit  = 1'b0;
      next_state      = OP_IDLE;
      next_timer      = '0;
    end

    next_stall = next_start_bit;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state               <= OP_IDLE;
      key                 <= KEY_NONE;
      start_bit           <= 1'b0;
      allow_bit           <= 1'b0;
      abort_flag          <= 1'b0;
      erase_sel           <= 1'b0;
      op_sel              <= 4'h0;
      target_address_low  <= 16'h0000;
      target_address_high <= 8'h00;
      timer               <= '0;
      rd_idx              <= '0;
      rd_pend             <= 1'b0;
      SFR_RDATA           <= 16'h0000;
      TBL_DONE            <= 1'b0;
      CPU_STALL           <= 1'b0;
      FLASH_DONE_FLAG     <= 1'b0;
      FL_ERASE            <= 1'b0;
      FL_PROG             <= 1'b0;
      FL_ROW              <= 18'h0_0000;
    end
    else
    begin
      state               <= next_state;
      key                 <= next_key;
      start_bit           <= next_start_bit;
      allow_bit           <= next_allow_bit;
      abort_flag          <= next_abort_flag;
      erase_sel           <= next_erase_sel;
      op_sel              <= next_op_sel;
      target_address_low  <= next_target_address_low;
      target_address_high <= next_target_address_high;
      timer               <= next_timer;
      rd_idx              <= next_rd_idx;
      rd_pend             <= next_rd_pend;
      SFR_RDATA           <= next_rdata;
      TBL_DONE            <= next_tbl_done;
      CPU_STALL           <= next_stall;
      FLASH_DONE_FLAG     <= next_done_flag;
      FL_ERASE            <= next_fl_erase;
      FL_PROG             <= next_fl_prog;
      FL_ROW              <= next_fl_row;
    end
  end
endmodule
`default_nettype wire

// *** dv/flash_array_model.sv ***
// Flash array stand-in that takes the program word stream
`default_nettype none
module flash_array_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Controller side
  input  wire logic        fl_erase,
  input  wire logic        fl_prog,
  input  wire logic [17:0] fl_row,
  input  wire logic        fl_valid,
  output logic             fl_ready,
  input  wire logic [23:0] fl_data,
  // Bench side
  input  wire logic        hold,
  output logic             got,
  output logic      [23:0] got_word,
  output logic      [17:0] op_row
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr;
  logic [4:0] wait_cnt;
  // Refuse words at first so the word buffer fills up
  assign fl_ready = !hold && wait_cnt == 5'h00 && lfsr[0];
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lfsr     <= 8'h5a;
      wait_cnt <= 5'h00;
      got      <= 1'b0;
      got_word <= 24'h00_0000;
      op_row   <= 18'h0_0000;
    end
    else
    begin
      lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      wait_cnt <= fl_prog ? 5'h18 : wait_cnt - 5'(wait_cnt != 5'h00);
      got      <= fl_valid && fl_ready;
      if (fl_valid && fl_ready)
        got_word <= fl_data;
      if (fl_erase || fl_prog)
        op_row <= fl_row;
    end
  end
endmodule
`default_nettype wire

// *** dv/self_program_flash_row_ctrl_properties.sv ***
// Port-level assertions of the row flash controller
`default_nettype none
`include "flash_row_params.svh"
module self_program_flash_row_ctrl_properties #(
  parameter int OP_CYCLES = 20
) (
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  // Core side
  input wire logic        SFR_RE,
  input wire logic [15:0] SFR_ADDR,
  input wire logic [15:0] SFR_RDATA,
  input wire logic        TBL_WE,
  input wire logic        TBL_DONE,
  input wire logic        CPU_STALL,
  input wire logic        FLASH_DONE_FLAG,
  input wire logic        FLASH_DONE_CLR,
  input wire logic        RESET_ABORT_REQ,
  // Flash side
  input wire logic        FL_ERASE,
  input wire logic        FL_PROG,
  input wire logic [17:0] FL_ROW,
  input wire logic        FL_VALID,
  input wire logic        FL_READY,
  input wire logic [23:0] FL_DATA
);
  logic [31:0] cnt, next_cnt;
  logic        ab, next_ab;
  logic [6:0]  wcnt, next_wcnt;
  // Stall length, abort seen, words taken since launch
  always_comb
  begin
    next_cnt  = CPU_STALL ? cnt + 32'h0000_0001 : 32'h0000_0000;
    next_ab   = CPU_STALL && (ab || RESET_ABORT_REQ);
    next_wcnt = FL_PROG ? 7'h00 : wcnt + 7'(FL_VALID && FL_READY);
  end
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt  <= 32'h0000_0000;
      ab   <= 1'b0;
      wcnt <= 7'h00;
    end
    else
    begin
      cnt  <= next_cnt;
      ab   <= next_ab;
      wcnt <= next_wcnt;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  tbl_done_a: assert property (TBL_WE |=> TBL_DONE)
    else $error("table write not acknowledged");
  tbl_lone_a: assert property (TBL_DONE |-> $past(TBL_WE))
    else $error("table done without write");
  key_read_a: assert property (SFR_RE && SFR_ADDR == `ADDR_UNLOCK_KEY
    |=> SFR_RDATA == 16'h0000)
    else $error("key register readable");
  launch_a: assert property ($rose(CPU_STALL) |-> FL_ERASE || FL_PROG)
    else $error("stall without launch");
  one_op_a: assert property (FL_ERASE || FL_PROG |-> CPU_STALL && !(FL_ERASE && FL_PROG)
    ##1 !FL_ERASE && !FL_PROG)
    else $error("launch not a single pulse");
  op_time_a: assert property ($fell(CPU_STALL) && !ab |-> cnt >= OP_CYCLES - 1)
    else $error("operation ended early");
  done_set_a: assert property ($fell(CPU_STALL) && !ab |-> ##[0:1] FLASH_DONE_FLAG)
    else $error("done flag not set");
  done_hold_a: assert property (FLASH_DONE_FLAG && !FLASH_DONE_CLR |=> FLASH_DONE_FLAG)
    else $error("done flag dropped");
  data_hold_a: assert property (FL_VALID && !FL_READY && !RESET_ABORT_REQ
    |=> FL_VALID && $stable(FL_DATA))
    else $error("word changed before accept");
  stream_busy_a: assert property (FL_VALID |-> CPU_STALL)
    else $error("word offered outside operation");
  row_words_a: assert property (wcnt <= 7'h20)
    else $error("more than one row of words");
  row_hold_a: assert property (CPU_STALL && $past(CPU_STALL) |-> $stable(FL_ROW))
    else $error("row changed during operation");
  abort_end_a: assert property (RESET_ABORT_REQ && CPU_STALL |-> ##[1:8] !CPU_STALL)
    else $error("abort did not end operation");
  cover property (FL_ERASE);
  cover property (FL_PROG);
  cover property (FL_VALID && !FL_READY);
  cover property (RESET_ABORT_REQ && CPU_STALL);
endmodule
bind self_program_flash_row_ctrl self_program_flash_row_ctrl_properties
  #(.OP_CYCLES(OP_CYCLES)) props_inst (.*);
`default_nettype wire

// *** dv/self_program_flash_row_ctrl_tb.sv ***
// Self-checking bench of the row flash controller
`default_nettype none
`include "flash_row_params.svh"
module self_program_flash_row_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OPC = 20;
  logic        CORE_CLK = 0, RST_N = 0, SFR_WE = 0, SFR_RE = 0, TBL_WE = 0, TBL_RE = 0;
  logic        TBL_HIGH = 0, FLASH_DONE_CLR = 0, RESET_ABORT_REQ = 0, hold = 0, re_d = 0;
  logic [15:0] SFR_ADDR = 0, SFR_WDATA = 0, TBL_EA = 0, TBL_WDATA = 0;
  logic [7:0]  TABLE_PAGE_REG = 0;
  logic        TBL_DONE, CPU_STALL, FLASH_DONE_FLAG, FL_ERASE, FL_PROG, FL_VALID, FL_READY, got;
  logic [15:0] SFR_RDATA;
  logic [17:0] FL_ROW, op_row;
  logic [23:0] FL_DATA, got_word;
  logic [15:0] exp_q[$];
  logic [23:0] word_q[$];
  logic [31:0] seed = 32'h011f_1a4e;
  int          mismatches = 0, n_checks = 0, cycles = 0;
  always #20 CORE_CLK = ~CORE_CLK;
  self_program_flash_row_ctrl #(.OP_CYCLES(OPC)) self_program_flash_row_ctrl_inst (.*);
  flash_array_model flash_array_model_inst (.clk(CORE_CLK), .rst_n(RST_N), .fl_erase(FL_ERASE),
    .fl_prog(FL_PROG), .fl_row(FL_ROW), .fl_valid(FL_VALID), .fl_ready(FL_READY),
    .fl_data(FL_DATA), .hold(hold), .got(got), .got_word(got_word), .op_row(op_row));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("BAD %0t got %h want %h", $time, g, e);
      mismatches++;
    end
  endtask
  task flag(input logic f, input logic e);
    chk({23'h00_0000, f}, {23'h00_0000, e});
  endtask
  task finish_test;
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge CORE_CLK);
    {SFR_WE, SFR_ADDR, SFR_WDATA} = {1'b1, a, d};
    @(negedge CORE_CLK);
    SFR_WE = 0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge CORE_CLK);
    {SFR_RE, SFR_ADDR} = {1'b1, a};
    exp_q.push_back(e);
    @(negedge CORE_CLK);
    SFR_RE = 0;
  endtask
  task tw(input logic hi, input logic [15:0] ea, input logic [15:0] d);
    @(negedge CORE_CLK);
    {TBL_WE, TBL_HIGH, TBL_EA, TBL_WDATA} = {1'b1, hi, ea, d};
    @(negedge CORE_CLK);
    TBL_WE = 0;
  endtask
  task unlock;
    wr(`ADDR_UNLOCK_KEY, `KEY_FIRST);
    wr(`ADDR_UNLOCK_KEY, `KEY_SECOND);
  endtask
  task idle;
    for (int i = 0; i < 400 && CPU_STALL !== 1'b0; i++)
      @(negedge CORE_CLK);
    @(negedge CORE_CLK);
    flag(CPU_STALL, 1'b0);
  endtask
  // Read data one cycle after the strobe, stream words as taken
  always @(posedge CORE_CLK) re_d <= SFR_RE;
  always @(negedge CORE_CLK)
  begin
    if (re_d)
      chk({8'h00, SFR_RDATA}, {8'h00, exp_q.pop_front()});
    if (got)
      chk(got_word, word_q.size() > 0 ? word_q.pop_front() : ~got_word);
    cycles++;
    if (cycles > 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
  initial
  begin
    logic [31:0] v;
    repeat (5) @(negedge CORE_CLK);
    RST_N = 1;
    rd(`ADDR_OP_CONTROL, `CTRL_RESET);
    rd(`ADDR_UNLOCK_KEY, 16'h0000);
    rd(16'h0770, 16'h0000);
    wr(`ADDR_TARGET_LOW, 16'h1234);
    wr(`ADDR_TARGET_HIGH, 16'hab5c);
    rd(`ADDR_TARGET_LOW, 16'h1234);
    rd(`ADDR_TARGET_HIGH, 16'h005c);
    wr(`ADDR_OP_CONTROL, 16'h4041);
    unlock();
    wr(`ADDR_OP_CONTROL, 16'hc041);
    wr(`ADDR_OP_CONTROL, 16'h0000);
    idle();
    flag(FLASH_DONE_FLAG, 1'b1);
    chk({6'h00, op_row}, 24'h5c_1234 >> 6);
    rd(`ADDR_OP_CONTROL, 16'h4041);
    FLASH_DONE_CLR = 1;
    @(negedge CORE_CLK);
    FLASH_DONE_CLR = 0;
    flag(FLASH_DONE_FLAG, 1'b0);
    TABLE_PAGE_REG = 8'h02;
    for (int i = 0; i < 32; i++)
    begin
      v = rnd();
      word_q.push_back(v[23:0]);
      tw(1'b0, 16'(16'h0040 + 2 * i), v[15:0]);
      tw(1'b1, 16'(16'h0040 + 2 * i), v[31:16]);
    end
    flag(FL_VALID, 1'b0);
    rd(`ADDR_TARGET_LOW, 16'h007e);
    rd(`ADDR_TARGET_HIGH, 16'h0002);
    @(negedge CORE_CLK);
    {TBL_RE, TBL_EA} = {1'b1, 16'h0046};
    @(negedge CORE_CLK);
    TBL_RE = 0;
    rd(`ADDR_TARGET_LOW, 16'h0046);
    for (int k = 0; k < 3; k++)
    begin
      wr(`ADDR_UNLOCK_KEY, k == 2 ? 16'h0056 : `KEY_FIRST);
      if (k == 0)
        wr(`ADDR_TARGET_HIGH, 16'h0002);
      wr(`ADDR_UNLOCK_KEY, `KEY_SECOND);
      wr(`ADDR_OP_CONTROL, k == 1 ? 16'h8001 : 16'hc001);
      repeat (3) @(negedge CORE_CLK);
      flag(CPU_STALL, 1'b0);
    end
    wr(`ADDR_OP_CONTROL, 16'h4001);
    unlock();
    wr(`ADDR_OP_CONTROL, 16'hc001);
    idle();
    chk(24'(word_q.size()), 24'h00_0000);
    chk({6'h00, op_row}, 24'h02_0046 >> 6);
    hold = 1;
    unlock();
    wr(`ADDR_OP_CONTROL, 16'hc001);
    repeat (10) @(negedge CORE_CLK);
    RESET_ABORT_REQ = 1;
    @(negedge CORE_CLK);
    RESET_ABORT_REQ = 0;
    idle();
    flag(FL_VALID, 1'b0);
    rd(`ADDR_OP_CONTROL, 16'h6001);
    rd(`ADDR_TARGET_LOW, 16'h0046);
    rd(`ADDR_TARGET_HIGH, 16'h0002);
    @(negedge CORE_CLK);
    finish_test();
  end
endmodule
`default_nettype wire
